// *** design/cmpc_pkg.sv ***
// Package for the comparator control logic: register map, field positions,
// reset values, structs and enums shared by the top and its synchroniser.
// Assumes an 8-bit register port with read data one cycle after the strobe.
package cmpc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [1:0] CMPC_ADDR_CTRL   = 2'h0;
  localparam logic [1:0] CMPC_ADDR_STATUS = 2'h1;
  localparam logic [1:0] CMPC_ADDR_MASK   = 2'h2;
  localparam logic [1:0] CMPC_ADDR_PORT   = 2'h3;

  // ==========================================================================
  // Control register field positions
  localparam int CMPC_BIT_PIN_SEL = 7;
  localparam int CMPC_BIT_POWER   = 6;
  localparam int CMPC_BIT_INVERT  = 5;
  localparam int CMPC_BIT_RESULT  = 4;
  localparam int CMPC_BIT_OUT_INT = 3;
  localparam int CMPC_BIT_EDGE_HI = 2;
  localparam int CMPC_BIT_EDGE_LO = 1;
  localparam int CMPC_BIT_HYST    = 0;

  // Status and mask bit positions
  localparam int CMPC_ST_EDGE = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CMPC_CTRL_RESET = 8'h81;
  localparam logic [7:0] CMPC_ZERO8      = 8'h00;
  localparam logic [1:0] CMPC_SYNC_RESET = 2'h0;

  // Edge selection encodings
  typedef enum logic [1:0] {
    CMPC_EDGE_RISE = 2'b00,
    CMPC_EDGE_FALL = 2'b01,
    CMPC_EDGE_BOTH = 2'b10,
    CMPC_EDGE_ANY  = 2'b11
  } cmpc_edge_e;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cmpc_bus_s;

  // Analog and pad controls
  typedef struct packed {
    logic power_on;
    logic hyst_on;
    logic pin_select;
    logic pullup_kill;
    logic out_pin;
    logic out_pin_en;
  } cmpc_ana_s;

  // All state of the top module
  typedef struct packed {
    logic [7:0] ctrl;
    logic       result;
    logic       status;
    logic       mask;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    cmpc_ana_s  ana;
  } cmpc_state_s;

endpackage

// *** design/cmpc_sync.sv ***
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a raw level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module cmpc_sync
  import cmpc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] ff;
  } cmpc_sync_s;

  cmpc_sync_s st_r;
  cmpc_sync_s st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.ff = {st_r.ff[0], i_async};
  end

  // Register the state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r.ff <= CMPC_SYNC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.ff[1];

endmodule
`default_nettype wire

// *** design/cmpc_top.sv ***
// Comparator control logic: control register, result capture, edge
// interrupt, wake-up request and pad steering around an analog comparator.
// Assumes the comparator decision is asynchronous and the port latch,
// direction bits and sleep indication come from logic on i_clk.
//
// How it works
// - Comparator enabled drops shared pin pull-ups
// - Selected result edge sets flag, raises irq
// - Edge field: rise, fall, or both
// - Edges taken on stored result bit
// - Flag set during sleep also requests wake
// - Sleep never clears the power bit
// - Shared pin reads zero when direction is input, only while pin select set
// - Pin select routes pins to comparator inputs
// - Power bit switches comparator on or off
// - Invert bit flips decision into result
// - Result bit read-only, reflects polarity
// - Output path bit gates dedicated output pin
// - Hysteresis bit drives hysteresis enable
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cmpc_top
  import cmpc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cmp_decision,
  input  wire logic       i_sleep,
  input  wire logic [1:0] i_port_latch,
  input  wire logic [1:0] i_port_dir,
  output logic            o_irq,
  output logic            o_wake,
  output logic            o_cmp_power_on,
  output logic            o_cmp_hyst_on,
  output logic            o_cmp_pin_select,
  output logic            o_pullup_kill,
  output logic            o_cmp_out_pin,
  output logic            o_cmp_out_pin_en
);

  // ==========================================================================
  // Synchronised comparator decision
  logic decision_sync;

  // Decision crosses into i_clk before any logic looks at it
  cmpc_sync u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_cmp_decision),
    .o_sync  (decision_sync)
  );

  // ==========================================================================
  // State
  cmpc_state_s st_r;
  cmpc_state_s st_nxt;
  cmpc_bus_s   bus;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       new_result;
    logic       rise;
    logic       fall;
    logic       hit;
    logic       enabled;
    logic [1:0] port_rd;
    cmpc_edge_e edge_sel;
    new_result = 1'b0;
    rise       = 1'b0;
    fall       = 1'b0;
    hit        = 1'b0;
    enabled    = 1'b0;
    port_rd    = 2'h0;
    edge_sel   = CMPC_EDGE_RISE;
    st_nxt     = st_r;

    // Control writes; the result bit is not writable, and sleep entry
    // has no path to the power bit at all
    if (bus.wr && bus.addr == CMPC_ADDR_CTRL) begin
      st_nxt.ctrl = bus.wdata;
    end
    if (bus.wr && bus.addr == CMPC_ADDR_MASK) begin
      st_nxt.mask = bus.wdata[CMPC_ST_EDGE];
    end

    // A powered-down comparator gives no decision; result holds
    enabled = st_r.ctrl[CMPC_BIT_POWER];
    if (enabled) begin
      new_result = decision_sync ^ st_r.ctrl[CMPC_BIT_INVERT];
    end else begin
      new_result = st_r.result;
    end
    st_nxt.result = new_result;

    // Edges are seen on the stored bit, never on the pad
    rise     = new_result & ~st_r.result;
    fall     = ~new_result & st_r.result;
    edge_sel = cmpc_edge_e'(st_r.ctrl[CMPC_BIT_EDGE_HI:CMPC_BIT_EDGE_LO]);
    unique case (edge_sel)
      CMPC_EDGE_RISE: hit = rise;
      CMPC_EDGE_FALL: hit = fall;
      CMPC_EDGE_BOTH,
      CMPC_EDGE_ANY:  hit = rise | fall;
    endcase

    // Write-one-to-clear on status; a new edge wins over the clear
    if (bus.wr && bus.addr == CMPC_ADDR_STATUS && bus.wdata[CMPC_ST_EDGE]) begin
      st_nxt.status = 1'b0;
    end
    if (hit) begin
      st_nxt.status = 1'b1;
    end

    // Interrupt level while unmasked flag stands
    st_nxt.irq = st_nxt.status & st_nxt.mask;

    // Wake only on a fresh flag; a flag already high gives no new rise
    st_nxt.wake = i_sleep & enabled & hit & ~st_r.status;

    // Pad and analog controls
    st_nxt.ana.power_on    = st_nxt.ctrl[CMPC_BIT_POWER];
    st_nxt.ana.hyst_on     = st_nxt.ctrl[CMPC_BIT_HYST];
    st_nxt.ana.pin_select  = st_nxt.ctrl[CMPC_BIT_PIN_SEL];
    st_nxt.ana.pullup_kill = st_nxt.ctrl[CMPC_BIT_POWER]
                           | st_nxt.ctrl[CMPC_BIT_PIN_SEL];
    st_nxt.ana.out_pin_en  = ~st_nxt.ctrl[CMPC_BIT_OUT_INT];
    st_nxt.ana.out_pin     = st_nxt.result & ~st_nxt.ctrl[CMPC_BIT_OUT_INT];

    // Port view of the shared pins while the comparator owns them
    if (st_r.ctrl[CMPC_BIT_PIN_SEL]) begin
      port_rd = i_port_latch & ~i_port_dir;
    end else begin
      port_rd = i_port_latch;
    end

    // Read data, valid only in the cycle after the strobe
    st_nxt.rdata = CMPC_ZERO8;
    if (bus.rd) begin
      unique case (bus.addr)
        CMPC_ADDR_CTRL: begin
          st_nxt.rdata = st_r.ctrl;
          st_nxt.rdata[CMPC_BIT_RESULT] = st_r.result;
        end
        CMPC_ADDR_STATUS: st_nxt.rdata = {7'h00, st_r.status};
        CMPC_ADDR_MASK:   st_nxt.rdata = {7'h00, st_r.mask};
        CMPC_ADDR_PORT:   st_nxt.rdata = {6'h00, port_rd};
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r.ctrl   <= CMPC_CTRL_RESET;
      st_r.result <= 1'b0;
      st_r.status <= 1'b0;
      st_r.mask   <= 1'b0;
      st_r.rdata  <= CMPC_ZERO8;
      st_r.irq    <= 1'b0;
      st_r.wake   <= 1'b0;
      st_r.ana    <= '{power_on: 1'b0, hyst_on: 1'b1, pin_select: 1'b1,
                       pullup_kill: 1'b1, out_pin: 1'b0, out_pin_en: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata          = st_r.rdata;
  assign o_irq            = st_r.irq;
  assign o_wake           = st_r.wake;
  assign o_cmp_power_on   = st_r.ana.power_on;
  assign o_cmp_hyst_on    = st_r.ana.hyst_on;
  assign o_cmp_pin_select = st_r.ana.pin_select;
  assign o_pullup_kill    = st_r.ana.pullup_kill;
  assign o_cmp_out_pin    = st_r.ana.out_pin;
  assign o_cmp_out_pin_en = st_r.ana.out_pin_en;

endmodule
`default_nettype wire

// *** tb/cmpc_analog_model.sv ***
// Partner: analog comparator core with a settling delay.
// Assumes the bench moves the input voltages through set_above.
`timescale 1ns/10ps
`default_nettype none
module cmpc_analog_model (
  input  wire logic i_power_on,
  output logic      o_decision
);
  // ========
  logic level = 1'b0;
  logic noise = 1'b0;
  // Decision settles part of a cycle after the inputs move
  task automatic set_above(input logic v);
    #1.7 level = v;
  endtask
  // An unpowered core has no valid decision, so keep it moving
  always #3 noise = ~noise;
  // One driver for the decision: settled level when powered, noise when not
  assign o_decision = i_power_on ? level : noise;
endmodule
`default_nettype wire

// *** tb/cmpc_props.sv ***
// Checker on the comparator control top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module cmpc_props (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       o_wake,
  input wire logic       o_cmp_power_on,
  input wire logic       o_cmp_hyst_on,
  input wire logic       o_cmp_pin_select,
  input wire logic       o_pullup_kill,
  input wire logic       o_cmp_out_pin,
  input wire logic       o_cmp_out_pin_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ========
  // Written value kept locally; the copies land one edge later
  property p_copy;
    logic [7:0] d;
    (i_wr && i_addr == 2'h0, d = i_wdata) |=> {o_cmp_pin_select, o_cmp_power_on,
      o_cmp_hyst_on, o_cmp_out_pin_en} == {d[7:6], d[0], !d[3]};
  endproperty
  property p_read;
    logic r;
    (i_rd && i_addr == 2'h0 && o_cmp_out_pin_en, r = o_cmp_out_pin) |=> o_rdata[4] == r;
  endproperty
  property p_off;
    (!o_cmp_power_on && o_cmp_out_pin_en) [*2] |-> $stable(o_cmp_out_pin);
  endproperty
  a_pullup_kill: assert property (o_pullup_kill == (o_cmp_power_on | o_cmp_pin_select))
    else $error("bad pull-up kill");
  a_pin_gated: assert property (!o_cmp_out_pin_en |-> !o_cmp_out_pin)
    else $error("pin driven while internal");
  a_ctrl_copy: assert property (p_copy)
    else $error("bad control copy");
  a_result_read: assert property (p_read)
    else $error("bad result read");
  a_irq_held: assert property ($fell(o_irq) |-> $past(i_wr))
    else $error("irq fell unasked");
  a_wake_single: assert property (o_wake |=> !o_wake)
    else $error("wake too long");
  a_wake_power: assert property (o_wake |-> o_cmp_power_on)
    else $error("wake while off");
  a_off_hold: assert property (p_off)
    else $error("result moved while off");
  c_irq: cover property ($rose(o_irq));
  c_wake: cover property (o_wake);
  c_read: cover property (i_rd && i_addr == 2'h0);
endmodule
bind cmpc_top cmpc_props props_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_wake(o_wake), .o_cmp_power_on(o_cmp_power_on),
  .o_cmp_hyst_on(o_cmp_hyst_on), .o_cmp_pin_select(o_cmp_pin_select),
  .o_pullup_kill(o_pullup_kill), .o_cmp_out_pin(o_cmp_out_pin),
  .o_cmp_out_pin_en(o_cmp_out_pin_en)
);
`default_nettype wire

// *** tb/cmpc_top_tb_top.sv ***
// Bench for the comparator control logic: random and directed parts.
// Assumes the analog model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module cmpc_top_tb_top
  import cmpc_pkg::*;
;
  logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_sleep = 1'b0;
  logic [1:0]  i_addr = 2'h0, i_port_latch = 2'h0, i_port_dir = 2'h0;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  logic        o_irq, o_wake, o_cmp_power_on, o_cmp_hyst_on, o_cmp_pin_select, r;
  logic        o_pullup_kill, o_cmp_out_pin, o_cmp_out_pin_en, i_cmp_decision;
  logic [31:0] s = 32'h743D;
  int          fails = 0, tests_run = 0, n = 0;
  wire  [3:0]  cp = {o_cmp_pin_select, o_cmp_power_on, o_cmp_hyst_on, o_cmp_out_pin_en};
  // ========
  cmpc_top dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_decision(i_cmp_decision), .i_sleep(i_sleep),
    .i_port_latch(i_port_latch), .i_port_dir(i_port_dir), .o_irq(o_irq), .o_wake(o_wake),
    .o_cmp_power_on(o_cmp_power_on), .o_cmp_hyst_on(o_cmp_hyst_on),
    .o_cmp_pin_select(o_cmp_pin_select), .o_pullup_kill(o_pullup_kill),
    .o_cmp_out_pin(o_cmp_out_pin), .o_cmp_out_pin_en(o_cmp_out_pin_en)
  );
  cmpc_analog_model model_u (.i_power_on(o_cmp_power_on), .o_decision(i_cmp_decision));
  initial forever #4 i_clk = ~i_clk;
  // Whole run needs about a thousand cycles
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
  endtask
  // Moves the inputs, then counts wake pulses; the wait covers sync and flag
  task automatic move(input logic v);
    n = 0;
    model_u.set_above(v);
    repeat (8) begin
      @(posedge i_clk);
      #1;
      if (o_wake !== 1'b0) n++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(0, CMPC_ADDR_CTRL, 8'h00);
    chk(o_rdata, CMPC_CTRL_RESET);
    chk({3'h0, o_pullup_kill, cp}, 8'h1B);
    // Random control values with random port views
    repeat (16) begin
      s = lfsr(s);
      @(posedge i_clk);
      i_port_latch <= s[9:8];
      i_port_dir <= s[11:10];
      bus(1, CMPC_ADDR_CTRL, s[7:0]);
      chk({3'h0, o_pullup_kill, cp}, {3'h0, s[7] | s[6], s[7:6], s[0], !s[3]});
      bus(0, CMPC_ADDR_CTRL, 8'h00);
      chk(o_rdata & 8'hEF, s[7:0] & 8'hEF);
      bus(0, CMPC_ADDR_PORT, 8'h00);
      chk(o_rdata, {6'h0, s[9:8] & ~(s[11:10] & {2{s[7]}})});
    end
    // Every edge mode, both polarities, output pin on and off
    bus(1, CMPC_ADDR_MASK, 8'h01);
    for (int m = 0; m < 16; m++) begin
      bus(1, CMPC_ADDR_CTRL, {2'b11, m[2], 1'b0, m[3], m[1:0], 1'b0});
      move(1'b0);
      bus(1, CMPC_ADDR_STATUS, 8'h01);
      for (int d = 1; d >= 0; d--) begin
        r = d[0] ^ m[2];
        move(d[0]);
        chk(n[7:0], 8'h00);
        bus(0, CMPC_ADDR_STATUS, 8'h00);
        chk(o_rdata, {7'h0, m[1] | (m[0] ^ r)});
        chk({6'h0, o_irq, o_cmp_out_pin}, {6'h0, m[1] | (m[0] ^ r), r & !m[3]});
        bus(0, CMPC_ADDR_CTRL, 8'h00);
        chk(o_rdata & 8'h10, {3'h0, r, 4'h0});
        bus(1, CMPC_ADDR_STATUS, 8'h01);
      end
    end
    // Unpowered core may wander; the flag must not move
    bus(1, CMPC_ADDR_CTRL, 8'h84);
    bus(1, CMPC_ADDR_STATUS, 8'h01);
    move(1'b1);
    bus(0, CMPC_ADDR_STATUS, 8'h00);
    chk(o_rdata, 8'h00);
    // Asleep: first change wakes, the flag left set blocks the next
    bus(1, CMPC_ADDR_MASK, 8'h00);
    bus(1, CMPC_ADDR_CTRL, 8'h44);
    move(1'b0);
    bus(1, CMPC_ADDR_STATUS, 8'h01);
    @(posedge i_clk);
    i_sleep <= 1'b1;
    move(1'b1);
    chk({6'h0, o_irq, o_cmp_power_on}, 8'h01);
    chk(n[7:0], 8'h01);
    move(1'b0);
    chk(n[7:0], 8'h00);
    @(posedge i_clk);
    i_sleep <= 1'b0;
    bus(1, CMPC_ADDR_MASK, 8'h01);
    move(1'b0);
    chk({7'h0, o_irq}, 8'h01);
    bus(1, CMPC_ADDR_STATUS, 8'h01);
    move(1'b0);
    chk({7'h0, o_irq}, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
